// *** design/adcc_pkg.sv ***
package adcc_pkg;

   // ****************************************************************
   // register map
   // ****************************************************************
   localparam logic [31:0] ADDR_CONTROL = 32'h50001500;
   localparam logic [31:0] ADDR_CONTROL_SECOND = 32'h50001502;
   localparam logic [31:0] ADDR_CONTROL_THIRD = 32'h50001504;
   localparam logic [31:0] ADDR_INPUT_SELECT = 32'h50001506;
   localparam logic [31:0] ADDR_POSITIVE_OFFSET = 32'h50001508;
   localparam logic [31:0] ADDR_NEGATIVE_OFFSET = 32'h5000150a;
   localparam logic [31:0] ADDR_TRIM = 32'h5000150c;
   localparam logic [31:0] ADDR_INTERRUPT_CLEAR = 32'h5000150e;
   localparam logic [31:0] ADDR_RESULT = 32'h50001510;
   localparam logic [31:0] ADDR_IRQ_STATUS = 32'h50001520;
   localparam logic [31:0] ADDR_IRQ_MASK = 32'h50001522;

   // ****************************************************************
   // reset values and field layout
   // ****************************************************************
   localparam logic [15:0] RESET_CONTROL = 16'h0000;
   localparam logic [15:0] RESET_CONTROL_SECOND = 16'h0210;
   localparam logic [15:0] RESET_CONTROL_THIRD = 16'h0040;
   localparam logic [15:0] RESET_INPUT_SELECT = 16'h0000;
   localparam logic [15:0] RESET_OFFSET = 16'h0200;
   localparam logic [15:0] RESET_TRIM = 16'h0030;
   localparam logic [15:0] RESET_RESULT = 16'h0000;
   localparam logic [1:0] RESET_IRQ = 2'h0;
   localparam logic [15:0] CONTROL_WRITE_MASK = 16'h17ed;
   localparam logic [15:0] OFFSET_MASK = 16'h03ff;
   localparam logic [15:0] TRIM_MASK = 16'h0070;
   localparam int CONV_GO_BIT = 1;
   localparam int SPACING_MSB = 15;
   localparam int SPACING_LSB = 8;
   localparam int POWER_WAIT_MSB = 7;
   localparam int POWER_WAIT_LSB = 0;
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_READY_BIT = 1;
   localparam logic [3:0] TEMP_SENSOR_CHANNEL = 4'h4;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real INTERVAL_UNIT_MS = 1.024;
   localparam int INTERVAL_UNIT_CYCLES = $rtoi(INTERVAL_UNIT_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int POWER_WAIT_STEP_CYCLES = 4;

   typedef struct packed {
      logic [2:0] reserved_hi;
      logic temp_sensor_on;
      logic reserved_11;
      logic regulator_ref_hold;
      logic chopper_on;
      logic polarity_invert;
      logic input_mute;
      logic single_ended_sel;
      logic done_irq_unmask;
      logic conv_done_flag;
      logic dma_request_on;
      logic continuous_sel;
      logic conv_go;
      logic converter_power_on;
   } adcc_control_type;

   typedef enum logic [2:0] {
      ST_OFF = 3'b000,
      ST_WARM = 3'b001,
      ST_IDLE = 3'b010,
      ST_REQ = 3'b011,
      ST_DROP = 3'b100,
      ST_SPACE = 3'b101
   } adcc_state_type;

endpackage

// *** design/adcc_top.sv ***
// Behaviour
// (R1) Control bit 12 switches the die temperature sensor on, which the converter sees on input 4.
// (R2) Control bit 10 makes the regulator hold a sampled bandgap value instead of tracking it.
// (R3) With chopper mode on each conversion takes two samples of opposite sign and averages them.
// (R4) Control bit 8 inverts the polarity at converter input and output.
// (R5) Control bit 7 mutes the converter input so it samples mid-scale.
// (R6) Control bit 6 picks single-ended (1) or differential (0) input.
// (R7) Control bit 5 gates the conversion-done interrupt to the system interrupt controller.
// (R8) Bit 4 reads 1 after a conversion completes until any write to the interrupt-clear register.
// (R9) Control bit 3 enables the dma request path.
// (R10) In manual mode each start request yields exactly one result.
// (R11) In continuous mode, after a start, conversions repeat with results stored each time.
// (R12) Writing 1 to bit 1 starts a conversion; completion clears it and sets the done flag.
// (R13) Software must not write the start bit while it still reads as 1.
// (R14) Power-on brings the regulator up first and the converter after; power-off drops both.
// (R15) The wait before converter enable is the wait setting times four clocks, reset 0x40. A setting of 0 gets four clocks here.
// (R16) Continuous mode adds the spacing setting times 1.024 ms between conversions.
// (R17) The system interrupt line is the done flag and its unmask bit together.
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module adcc_top #(
   parameter int INTERVAL_CYCLES = adcc_pkg::INTERVAL_UNIT_CYCLES
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [31:0] bus_addr,
   input wire logic [15:0] bus_wdata,
   input wire logic bus_write,
   input wire logic bus_read,
   output logic [15:0] bus_rdata,
   output adcc_pkg::adcc_control_type adc_mode,
   output logic [15:0] adc_setup_second,
   output logic [15:0] adc_input_channel,
   output logic [15:0] adc_offset_pos,
   output logic [15:0] adc_offset_neg,
   output logic [15:0] adc_trim_word,
   output logic regulator_on,
   output logic converter_enable,
   output logic sample_req,
   output logic sample_sign,
   input wire logic sample_ack,
   input wire logic [15:0] sample_data,
   output logic dma_request,
   output logic system_irq,
   output logic irq
);

   // ****************************************************************
   // registers and state
   // ****************************************************************
   adcc_pkg::adcc_control_type control;
   logic [15:0] control_third;
   logic [15:0] result;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   adcc_pkg::adcc_state_type state;
   logic ack_meta;
   logic ack_sync;
   logic [9:0] wait_count;
   logic chop_phase;
   logic [15:0] first_sample;
   logic [15:0] second_sample;
   logic [7:0] space_count;
   logic [31:0] tick_count;
   logic finish;
   logic ready_event;
   logic [1:0] irq_events;

   function automatic logic hit(input logic [31:0] addr, input logic [31:0] target);
      hit = (addr == target);
   endfunction

   function automatic logic [15:0] average(input logic [15:0] a, input logic [15:0] b);
      logic [16:0] sum;
      sum = {1'b0, a} + {1'b0, b};
      average = sum[16:1];
   endfunction

   // ****************************************************************
   // acknowledge synchroniser
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
      end else begin
         ack_meta <= sample_ack;
         ack_sync <= ack_meta;
      end
   end

   // last sample of a conversion has been released by the macro
   assign finish = (state == adcc_pkg::ST_DROP) && !ack_sync
                   && (!control.chopper_on || chop_phase);
   assign ready_event = (state == adcc_pkg::ST_WARM) && (wait_count == 10'h000);
   assign irq_events = {ready_event, finish};

   // ****************************************************************
   // control register
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         control <= adcc_pkg::RESET_CONTROL;
      end else begin
         if (bus_write && hit(bus_addr, adcc_pkg::ADDR_CONTROL)) begin
            // R1 R2 R4 R5 R6 R7 R9 R14
            control <= (bus_wdata & adcc_pkg::CONTROL_WRITE_MASK)
                       | (control & ~adcc_pkg::CONTROL_WRITE_MASK);
         end
         // R12 R13
         if (bus_write && hit(bus_addr, adcc_pkg::ADDR_CONTROL)
             && bus_wdata[adcc_pkg::CONV_GO_BIT]) begin
            control.conv_go <= 1'b1;
         end else if (finish || !control.converter_power_on) begin
            control.conv_go <= 1'b0;
         end
         // R8
         if (finish) begin
            control.conv_done_flag <= 1'b1;
         end else if (bus_write && hit(bus_addr, adcc_pkg::ADDR_INTERRUPT_CLEAR)) begin
            control.conv_done_flag <= 1'b0;
         end
      end
   end

   // ****************************************************************
   // setup registers
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adc_setup_second <= adcc_pkg::RESET_CONTROL_SECOND;
         control_third <= adcc_pkg::RESET_CONTROL_THIRD;
         adc_input_channel <= adcc_pkg::RESET_INPUT_SELECT;
         adc_offset_pos <= adcc_pkg::RESET_OFFSET;
         adc_offset_neg <= adcc_pkg::RESET_OFFSET;
         adc_trim_word <= adcc_pkg::RESET_TRIM;
         irq_mask <= adcc_pkg::RESET_IRQ;
      end else if (bus_write) begin
         if (hit(bus_addr, adcc_pkg::ADDR_CONTROL_SECOND)) begin
            adc_setup_second <= bus_wdata;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_CONTROL_THIRD)) begin
            control_third <= bus_wdata;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_INPUT_SELECT)) begin
            adc_input_channel <= bus_wdata;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_POSITIVE_OFFSET)) begin
            adc_offset_pos <= bus_wdata & adcc_pkg::OFFSET_MASK;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_NEGATIVE_OFFSET)) begin
            adc_offset_neg <= bus_wdata & adcc_pkg::OFFSET_MASK;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_TRIM)) begin
            adc_trim_word <= bus_wdata & adcc_pkg::TRIM_MASK;
         end
         if (hit(bus_addr, adcc_pkg::ADDR_IRQ_MASK)) begin
            irq_mask <= bus_wdata[1:0];
         end
      end
   end

   // ****************************************************************
   // mode outputs to the macro
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         adc_mode <= adcc_pkg::RESET_CONTROL;
      end else begin
         adc_mode <= control; // R1 R2 R4 R5 R6
      end
   end

   // ****************************************************************
   // sequencer
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state <= adcc_pkg::ST_OFF;
         regulator_on <= 1'b0;
         converter_enable <= 1'b0;
         sample_req <= 1'b0;
         sample_sign <= 1'b0;
         wait_count <= 10'h000;
         chop_phase <= 1'b0;
         first_sample <= 16'h0000;
         second_sample <= 16'h0000;
         result <= adcc_pkg::RESET_RESULT;
         space_count <= 8'h00;
         tick_count <= 32'h00000000;
      end else if (!control.converter_power_on) begin
         state <= adcc_pkg::ST_OFF; // R14
         regulator_on <= 1'b0;
         converter_enable <= 1'b0;
         sample_req <= 1'b0;
      end else begin
         unique case (state)
            adcc_pkg::ST_OFF: begin
               regulator_on <= 1'b1; // R14
               // R15: a zero setting is treated as one step
               if (control_third[adcc_pkg::POWER_WAIT_MSB:adcc_pkg::POWER_WAIT_LSB] == 8'h00) begin
                  wait_count <= 10'(adcc_pkg::POWER_WAIT_STEP_CYCLES - 1);
               end else begin
                  wait_count <= 10'(control_third[adcc_pkg::POWER_WAIT_MSB:adcc_pkg::POWER_WAIT_LSB]
                                * adcc_pkg::POWER_WAIT_STEP_CYCLES - 1);
               end
               state <= adcc_pkg::ST_WARM;
            end
            adcc_pkg::ST_WARM: begin
               if (wait_count == 10'h000) begin
                  converter_enable <= 1'b1; // R14 R15
                  state <= adcc_pkg::ST_IDLE;
               end else begin
                  wait_count <= wait_count - 10'h001;
               end
            end
            adcc_pkg::ST_IDLE: begin
               if (control.conv_go) begin
                  sample_req <= 1'b1; // R12
                  sample_sign <= control.polarity_invert;
                  chop_phase <= 1'b0;
                  state <= adcc_pkg::ST_REQ;
               end
            end
            adcc_pkg::ST_REQ: begin
               if (ack_sync) begin
                  // data is only valid while the acknowledge stands
                  if (chop_phase) begin
                     second_sample <= sample_data; // R3
                  end else begin
                     first_sample <= sample_data;
                  end
                  sample_req <= 1'b0;
                  state <= adcc_pkg::ST_DROP;
               end
            end
            adcc_pkg::ST_DROP: begin
               if (!ack_sync) begin
                  if (control.chopper_on && !chop_phase) begin
                     chop_phase <= 1'b1; // R3
                     sample_sign <= !sample_sign;
                     sample_req <= 1'b1;
                     state <= adcc_pkg::ST_REQ;
                  end else begin
                     if (control.chopper_on) begin
                        result <= average(first_sample, second_sample); // R3
                     end else begin
                        result <= first_sample;
                     end
                     chop_phase <= 1'b0;
                     tick_count <= 32'h00000000;
                     space_count <= control_third[adcc_pkg::SPACING_MSB:adcc_pkg::SPACING_LSB];
                     if (control.continuous_sel) begin
                        state <= adcc_pkg::ST_SPACE; // R11
                     end else begin
                        state <= adcc_pkg::ST_IDLE; // R10
                     end
                  end
               end
            end
            adcc_pkg::ST_SPACE: begin
               if (!control.continuous_sel) begin
                  state <= adcc_pkg::ST_IDLE;
               end else if (space_count == 8'h00) begin
                  sample_req <= 1'b1; // R11
                  sample_sign <= control.polarity_invert;
                  state <= adcc_pkg::ST_REQ;
               end else if (tick_count == 32'(INTERVAL_CYCLES - 1)) begin
                  tick_count <= 32'h00000000; // R16
                  space_count <= space_count - 8'h01;
               end else begin
                  tick_count <= tick_count + 32'h00000001;
               end
            end
            default: begin
               state <= adcc_pkg::ST_OFF;
            end
         endcase
      end
   end

   // ****************************************************************
   // interrupts and dma
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq_status <= adcc_pkg::RESET_IRQ;
      end else if (bus_read && hit(bus_addr, adcc_pkg::ADDR_IRQ_STATUS)) begin
         irq_status <= irq_events;
      end else begin
         irq_status <= irq_status | irq_events;
      end
   end

   always_ff @(posedge core_clk) begin
      if (reset) begin
         irq <= 1'b0;
         system_irq <= 1'b0;
         dma_request <= 1'b0;
      end else begin
         irq <= |(irq_status & irq_mask);
         system_irq <= control.conv_done_flag && control.done_irq_unmask; // R7 R17
         dma_request <= finish && control.dma_request_on; // R9
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_ff @(posedge core_clk) begin
      if (reset) begin
         bus_rdata <= 16'h0000;
      end else if (!bus_read) begin
         bus_rdata <= 16'h0000;
      end else begin
         unique case (bus_addr)
            adcc_pkg::ADDR_CONTROL: bus_rdata <= control; // R8 R12
            adcc_pkg::ADDR_CONTROL_SECOND: bus_rdata <= adc_setup_second;
            adcc_pkg::ADDR_CONTROL_THIRD: bus_rdata <= control_third;
            adcc_pkg::ADDR_INPUT_SELECT: bus_rdata <= adc_input_channel;
            adcc_pkg::ADDR_POSITIVE_OFFSET: bus_rdata <= adc_offset_pos;
            adcc_pkg::ADDR_NEGATIVE_OFFSET: bus_rdata <= adc_offset_neg;
            adcc_pkg::ADDR_TRIM: bus_rdata <= adc_trim_word;
            adcc_pkg::ADDR_RESULT: bus_rdata <= result; // R11
            adcc_pkg::ADDR_IRQ_STATUS: bus_rdata <= {14'h0000, irq_status};
            adcc_pkg::ADDR_IRQ_MASK: bus_rdata <= {14'h0000, irq_mask};
            default: bus_rdata <= 16'h0000;
         endcase
      end
   end

endmodule

`default_nettype wire

// *** tb/adcc_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_checker (
   input wire logic core_clk,
   input wire logic reset,
   input wire adcc_pkg::adcc_control_type adc_mode,
   input wire logic regulator_on,
   input wire logic converter_enable,
   input wire logic sample_req,
   input wire logic sample_sign,
   input wire logic dma_request,
   input wire logic system_irq
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // ****************************************************************
   // power and conversion order
   // ****************************************************************
   reg_first_a: assert property ($rose(converter_enable) |-> $past(regulator_on))
      else $error("converter enabled before regulator");
   off_both_a: assert property (!regulator_on |-> !converter_enable)
      else $error("converter enabled without regulator");
   req_powered_a: assert property (sample_req |-> converter_enable)
      else $error("sample request while converter disabled");
   go_start_a: assert property ($rose(sample_req) |->
      adc_mode.conv_go || adc_mode.continuous_sel)
      else $error("sample request without start");
   done_clears_a: assert property ($rose(adc_mode.conv_done_flag) |-> !adc_mode.conv_go)
      else $error("done flag set while start bit still high");
   one_result_a: assert property ($fell(adc_mode.conv_go) && !adc_mode.continuous_sel
      |=> !sample_req [*4])
      else $error("extra sample after manual conversion");
   sign_plain_a: assert property ($rose(sample_req) && !adc_mode.chopper_on
      |-> sample_sign == adc_mode.polarity_invert)
      else $error("sample sign differs from polarity setting");
   chop_second_a: assert property ($fell(sample_req) && adc_mode.chopper_on && adc_mode.conv_go
      && sample_sign == adc_mode.polarity_invert
      |-> ##[1:40] $rose(sample_req) && sample_sign != adc_mode.polarity_invert)
      else $error("chopper second sample missing or same sign");
   // ****************************************************************
   // interrupt and dma
   // ****************************************************************
   irq_gate_a: assert property (adc_mode.conv_done_flag && adc_mode.done_irq_unmask
      |-> ##[0:1] system_irq)
      else $error("unmasked done flag not forwarded");
   irq_mask_a: assert property (!adc_mode.done_irq_unmask |-> ##[0:1] !system_irq)
      else $error("masked interrupt forwarded");
   dma_gate_a: assert property (dma_request |-> adc_mode.dma_request_on ##1 !dma_request)
      else $error("dma request wrong");
   cover property ($rose(converter_enable));
   cover property (dma_request && adc_mode.continuous_sel);
   cover property ($rose(sample_req) && sample_sign && adc_mode.chopper_on);
endmodule
bind adcc_top adcc_checker adcc_checker_inst (
   .core_clk(core_clk), .reset(reset), .adc_mode(adc_mode), .regulator_on(regulator_on),
   .converter_enable(converter_enable), .sample_req(sample_req), .sample_sign(sample_sign),
   .dma_request(dma_request), .system_irq(system_irq)
);
`default_nettype wire

// *** tb/adcc_macro_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module adcc_macro_model (
   input wire logic core_clk,
   input wire logic sample_req,
   input wire logic sample_sign,
   input wire logic [15:0] level,
   input wire logic [3:0] delay,
   output logic sample_ack,
   output logic [15:0] sample_data
);
   initial begin
      sample_ack = 1'b0;
      sample_data = 16'h0000;
      forever begin
         @(posedge core_clk);
         if (sample_req && !sample_ack) begin
            repeat (delay) @(posedge core_clk);
            sample_data <= sample_sign ? level + 16'h0003 : level;
            sample_ack <= 1'b1;
            do @(posedge core_clk); while (sample_req);
            sample_ack <= 1'b0;
            // released data shows a changed value, not the last sample
            sample_data <= ~sample_data;
         end
      end
   end
endmodule
`default_nettype wire

// *** tb/tb_adcc_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_adcc_top;
   localparam int IVL = 12;
   logic core_clk;
   logic reset;
   logic [31:0] bus_addr;
   logic [15:0] bus_wdata;
   logic bus_write;
   logic bus_read;
   logic [15:0] bus_rdata;
   adcc_pkg::adcc_control_type adc_mode;
   logic regulator_on;
   logic converter_enable;
   logic sample_req;
   logic sample_sign;
   logic sample_ack;
   logic [15:0] sample_data;
   logic dma_request;
   logic system_irq;
   logic irq;
   logic [15:0] level;
   logic [3:0] delay;
   logic [15:0] d;
   logic [15:0] o_sec, o_sel, o_pos, o_neg, o_trim;
   int n_mismatch;
   int total_checks;
   int lvl;
   int g0;
   int g1;
   logic [15:0] rst_val [9] = '{16'h0000, 16'h0210, 16'h0040, 16'h0000, 16'h0200, 16'h0200,
      16'h0030, 16'h0000, 16'h0000};
   logic [15:0] wmask [9] = '{16'h17ed, 16'hffff, 16'hffff, 16'hffff, 16'h03ff, 16'h03ff,
      16'h0070, 16'h0000, 16'h0000};
   logic [15:0] modes [6] = '{16'h0029, 16'h0109, 16'h0201, 16'h0301, 16'h14c1, 16'h0081};
   adcc_top #(.INTERVAL_CYCLES(IVL)) adcc_top_inst (
      .core_clk(core_clk), .reset(reset), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
      .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .adc_mode(adc_mode),
      .adc_setup_second(o_sec), .adc_input_channel(o_sel), .adc_offset_pos(o_pos),
      .adc_offset_neg(o_neg), .adc_trim_word(o_trim), .regulator_on(regulator_on),
      .converter_enable(converter_enable),
      .sample_req(sample_req), .sample_sign(sample_sign), .sample_ack(sample_ack),
      .sample_data(sample_data), .dma_request(dma_request), .system_irq(system_irq), .irq(irq)
   );
   adcc_macro_model adcc_macro_model_inst (
      .core_clk(core_clk), .sample_req(sample_req), .sample_sign(sample_sign), .level(level),
      .delay(delay), .sample_ack(sample_ack), .sample_data(sample_data)
   );
   // ****************************************************************
   // bus, model and check tasks
   // ****************************************************************
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [31:0] a, input logic [15:0] v);
      bus_addr <= a;
      bus_wdata <= v;
      bus_write <= 1'b1;
      @(posedge core_clk);
      bus_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic rdc(input logic [31:0] a, input logic [15:0] e);
      bus_addr <= a;
      bus_read <= 1'b1;
      @(posedge core_clk);
      bus_read <= 1'b0;
      @(posedge core_clk);
      check(bus_rdata, e);
   endtask
   function automatic logic [15:0] model(input int v, input logic chop, input logic inv);
      int r;
      r = chop ? (2 * v + 3) / 2 : (inv ? v + 3 : v);
      return r[15:0];
   endfunction
   function automatic logic [15:0] pin(input int i);
      return i == 1 ? o_sec : i == 3 ? o_sel : i == 4 ? o_pos : i == 5 ? o_neg : o_trim;
   endfunction
   task automatic wait_done;
      int k;
      k = 0;
      while (adc_mode.conv_done_flag !== 1'b1 && k < 300) begin
         @(posedge core_clk);
         k++;
      end
      check({15'h0, k < 300}, 16'h0001);
   endtask
   task automatic wait_dma(output int n);
      n = 0;
      while (dma_request !== 1'b1 && n < 500) begin
         @(posedge core_clk);
         n++;
      end
      check({15'h0, n < 500}, 16'h0001);
      @(posedge core_clk);
   endtask
   task automatic power_up(input logic [7:0] n);
      int c;
      c = 0;
      wr(adcc_pkg::ADDR_CONTROL, 16'h0000);
      wr(adcc_pkg::ADDR_CONTROL_THIRD, {8'h00, n});
      wr(adcc_pkg::ADDR_CONTROL, 16'h0001);
      for (int k = 0; k < 1100 && converter_enable !== 1'b1; k++) begin
         @(posedge core_clk);
         if (regulator_on === 1'b1 && converter_enable !== 1'b1) c++;
      end
      check(c[15:0], 16'(4 * (n == 8'h00 ? 1 : n)));
   endtask
   task automatic conv(input logic [15:0] ctl);
      lvl = $urandom() & 32'h7fff;
      level <= 16'(lvl);
      delay <= 4'($urandom_range(0, 6));
      wr(adcc_pkg::ADDR_CONTROL, ctl | 16'h0002);
      wait_done();
      rdc(adcc_pkg::ADDR_RESULT, model(lvl, ctl[9], ctl[8]));
      rdc(adcc_pkg::ADDR_CONTROL, (ctl & 16'h17ed) | 16'h0010);
      check(adc_mode, (ctl & 16'h17ed) | 16'h0010);
      check({15'h0, system_irq}, {15'h0, ctl[5]});
      wr(adcc_pkg::ADDR_INTERRUPT_CLEAR, 16'($urandom()));
      rdc(adcc_pkg::ADDR_CONTROL, ctl & 16'h17ed);
      check({15'h0, system_irq}, 16'h0000);
   endtask
   task automatic gap(input logic [7:0] sp, output int g);
      wr(adcc_pkg::ADDR_CONTROL, 16'h0001);
      repeat (40) @(posedge core_clk);
      wr(adcc_pkg::ADDR_CONTROL_THIRD, {sp, 8'h01});
      wr(adcc_pkg::ADDR_CONTROL, 16'h000f);
      wait_dma(g);
      wait_dma(g);
      wait_dma(g);
      wr(adcc_pkg::ADDR_CONTROL, 16'h0001);
   endtask
   task automatic stop_test;
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ****************************************************************
   // clock, watchdog and sequence
   // ****************************************************************
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      repeat (20000) @(posedge core_clk);
      n_mismatch++;
      stop_test();
   end
   initial begin
      reset = 1'b1;
      bus_addr = 32'h0;
      bus_wdata = 16'h0;
      bus_write = 1'b0;
      bus_read = 1'b0;
      level = 16'h0;
      delay = 4'h2;
      n_mismatch = 0;
      total_checks = 0;
      lvl = $urandom(32'hf774);
      repeat (20) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      for (int i = 0; i < 9; i++) begin
         if (i != 7) rdc(32'h50001500 + 32'(2 * i), rst_val[i]);
         if (i inside {1, 3, 4, 5, 6}) check(pin(i), rst_val[i]);
      end
      rdc(adcc_pkg::ADDR_IRQ_MASK, 16'h0000);
      rdc(32'h50001530, 16'h0000);
      for (int i = 0; i < 9; i++) begin
         d = 16'($urandom() & (i == 0 ? 32'hfffc : 32'hffff));
         if (i != 7) begin
            wr(32'h50001500 + 32'(2 * i), d);
            rdc(32'h50001500 + 32'(2 * i), d & wmask[i]);
            if (i inside {1, 3, 4, 5, 6}) check(pin(i), d & wmask[i]);
         end
      end
      power_up(8'h00);
      power_up(8'h03);
      rdc(adcc_pkg::ADDR_IRQ_STATUS, 16'h0002);
      rdc(adcc_pkg::ADDR_IRQ_STATUS, 16'h0000);
      conv(modes[0]);
      check({15'h0, irq}, 16'h0000);
      wr(adcc_pkg::ADDR_IRQ_MASK, 16'h0001);
      @(posedge core_clk);
      check({15'h0, irq}, 16'h0001);
      rdc(adcc_pkg::ADDR_IRQ_STATUS, 16'h0001);
      @(posedge core_clk);
      check({15'h0, irq}, 16'h0000);
      for (int i = 1; i < 6; i++) conv(modes[i]);
      delay <= 4'h3;
      gap(8'h00, g0);
      gap(8'h01, g1);
      check(16'(g1 - g0), 16'(IVL));
      wr(adcc_pkg::ADDR_CONTROL, 16'h0000);
      stop_test();
   end
endmodule
`default_nettype wire
